// file: lcd_segment_decoder_writer_map.vh
// Constants for the segment decoder and display-memory writer
`ifndef LCD_SEGMENT_DECODER_WRITER_MAP_VH
`define LCD_SEGMENT_DECODER_WRITER_MAP_VH

`define MUX_STATIC     2'h0
`define MUX_DIV2       2'h1
`define MUX_DIV3       2'h2
`define MUX_DIV4       2'h3

`define MEM_WORDS      32
`define PTR_WIDTH      5
`define PTR_RESET      5'h00

`define STEP_STATIC    3'h4
`define STEP_DIV2      3'h4
`define STEP_DIV3      3'h3
`define STEP_DIV4      3'h2
`define STEP_SEG7_DIV3 3'h3
`define STEP_SEG7_DIV4 3'h2
`define STEP_SEG14     3'h4

`define SEL_BIT        7

`endif

// file: lcd_segment_decoder_writer.v
// Segment decoder and sequential writer into the 32x4 display memory
//
// How it works
// - Seven-segment decoding in divide-by-3/4 modes, fourteen-segment only in divide-by-4.
// - Decoders cover digits, six symbols, 36 alphanumerics and 13 symbols.
// - With decoding on, each data byte valid for the mode is decoded and stored automatically; other data bytes are ignored.
// - Byte bit 7 low picks seven-segment, high picks fourteen-segment decoder.
// - Seven-segment decoding uses only the low four bits of the byte.
// - Fourteen-segment decoding uses the low seven bits of the byte.
// - Fourteen-segment codes follow the ASCII character assignment.
// - Nibbles go to N..N+2, N..N+1 or N..N+3 by decoder and mode.
// - Display memory holds 32 words of four bits.
// - Memory data comes from the raw byte or from the decoder output.
// - Raw bytes spread over two to four words according to the mode.
// - Decoded placement depends on multiplexing mode and byte bit 7.
// - Commands write a whole word or a single bit at the pointer.
// - Divide-by-3 clears bit 2 of N+2, and of N when decoded; pointer +3.
// - Divide-by-4 seven-segment clears bit 3 of N; pointer +2.
// - Fourteen-segment clears bit 3 of N+2 and bit 0 of N+1; pointer +4.
// - The five-bit pointer wraps from 31 to 0.
`timescale 1ns/1ps
`include "lcd_segment_decoder_writer_map.vh"

module lcd_segment_decoder_writer
(
  input  wire       SYS_CLK_I,
  input  wire       RST_N_I,
  input  wire       BYTE_VALID_I,
  input  wire [7:0] BYTE_I,
  input  wire       CMD_SEL_I,
  input  wire       DECODE_ON_I,
  input  wire [1:0] MUX_MODE_I,
  input  wire       PTR_CLEAR_I,
  input  wire       PTR_LOAD_I,
  input  wire [4:0] PTR_VALUE_I,
  input  wire       NIB_WRITE_I,
  input  wire [3:0] NIB_DATA_I,
  input  wire       BIT_WRITE_I,
  input  wire [1:0] BIT_SEL_I,
  input  wire       BIT_VALUE_I,
  input  wire [4:0] RD_ADDR_I,
  output reg  [3:0] RD_DATA_O,
  output reg  [4:0] DATA_PTR_O,
  output reg        BUSY_O
);

  localparam ST_IDLE  = 1'b0;
  localparam ST_WRITE = 1'b1;

  reg  [3:0]  mem [0:`MEM_WORDS-1];
  reg         state;
  reg  [15:0] buffer;
  reg  [2:0]  count;
  reg  [15:0] next_buffer;
  reg  [2:0]  next_count;
  reg         take;
  reg  [19:0] seg7;
  reg  [15:0] seg14;
  integer     i;

  // Returns {div3 N+2, N+1, N, div4 N+1, N}
  function [19:0] seg7_lookup;
    input [3:0] code;
    begin
      case (code)
        4'h0:    seg7_lookup = 20'h353d7;
        4'h1:    seg7_lookup = 20'h00306;
        4'h2:    seg7_lookup = 20'h271e3;
        4'h3:    seg7_lookup = 20'h073a7;
        4'h4:    seg7_lookup = 20'h12336;
        4'h5:    seg7_lookup = 20'h172b5;
        4'h6:    seg7_lookup = 20'h372f5;
        4'h7:    seg7_lookup = 20'h01307;
        4'h8:    seg7_lookup = 20'h373f7;
        4'h9:    seg7_lookup = 20'h173b7;
        4'ha:    seg7_lookup = 20'h02020;
        4'hb:    seg7_lookup = 20'h370f1;
        4'hc:    seg7_lookup = 20'h350d1;
        4'hd:    seg7_lookup = 20'h060a0;
        4'he:    seg7_lookup = 20'h262e4;
        default: seg7_lookup = 20'h00000;
      endcase
    end
  endfunction

  // Returns {N+3, N+2, N+1, N}; codes are ASCII
  function [15:0] seg14_lookup;
    input [6:0] code;
    begin
      case (code)
        7'h20:   seg14_lookup = 16'h0000;
        7'h27:   seg14_lookup = 16'h0002;
        7'h28:   seg14_lookup = 16'h000a;
        7'h29:   seg14_lookup = 16'h5000;
        7'h2a:   seg14_lookup = 16'hf00f;
        7'h2b:   seg14_lookup = 16'ha005;
        7'h2d:   seg14_lookup = 16'h2004;
        7'h2f:   seg14_lookup = 16'h4002;
        7'h30:   seg14_lookup = 16'h47e2;
        7'h31:   seg14_lookup = 16'h0600;
        7'h32:   seg14_lookup = 16'h23c4;
        7'h33:   seg14_lookup = 16'h2784;
        7'h34:   seg14_lookup = 16'h2624;
        7'h35:   seg14_lookup = 16'h25a4;
        7'h36:   seg14_lookup = 16'h25e4;
        7'h37:   seg14_lookup = 16'h0700;
        7'h38:   seg14_lookup = 16'h27e4;
        7'h39:   seg14_lookup = 16'h27a4;
        7'h3c:   seg14_lookup = 16'h4082;
        7'h3d:   seg14_lookup = 16'h2084;
        7'h3e:   seg14_lookup = 16'h1088;
        7'h40:   seg14_lookup = 16'ha7c0;
        7'h41:   seg14_lookup = 16'h2764;
        7'h42:   seg14_lookup = 16'h8785;
        7'h43:   seg14_lookup = 16'h01e0;
        7'h44:   seg14_lookup = 16'h8781;
        7'h45:   seg14_lookup = 16'h21e4;
        7'h46:   seg14_lookup = 16'h2164;
        7'h47:   seg14_lookup = 16'h05e4;
        7'h48:   seg14_lookup = 16'h2664;
        7'h49:   seg14_lookup = 16'h8181;
        7'h4a:   seg14_lookup = 16'h06c0;
        7'h4b:   seg14_lookup = 16'h206a;
        7'h4c:   seg14_lookup = 16'h00e0;
        7'h4d:   seg14_lookup = 16'h1662;
        7'h4e:   seg14_lookup = 16'h1668;
        7'h4f:   seg14_lookup = 16'h07e0;
        7'h50:   seg14_lookup = 16'h2364;
        7'h51:   seg14_lookup = 16'h07e8;
        7'h52:   seg14_lookup = 16'h236c;
        7'h53:   seg14_lookup = 16'h1584;
        7'h54:   seg14_lookup = 16'h8101;
        7'h55:   seg14_lookup = 16'h06e0;
        7'h56:   seg14_lookup = 16'h4062;
        7'h57:   seg14_lookup = 16'h4668;
        7'h58:   seg14_lookup = 16'h500a;
        7'h59:   seg14_lookup = 16'h9002;
        7'h5a:   seg14_lookup = 16'h4182;
        7'h5c:   seg14_lookup = 16'h1008;
        default: seg14_lookup = 16'h0000;
      endcase
    end
  endfunction

  // Nibble image and word count for one accepted data byte
  always @*
  begin
    seg7 = seg7_lookup(BYTE_I[3:0]);
    seg14 = seg14_lookup(BYTE_I[6:0]);
    next_buffer = 16'h0000;
    next_count = 3'h0;
    take = 1'b0;
    if (state == ST_IDLE && BYTE_VALID_I && !CMD_SEL_I)
    begin
      if (DECODE_ON_I)
      begin
        if (BYTE_I[`SEL_BIT])
        begin
          if (MUX_MODE_I == `MUX_DIV4)
          begin
            next_buffer = {seg14[15:12], 1'b0, seg14[10:8], seg14[7:5], 1'b0, seg14[3:0]};
            next_count = `STEP_SEG14;
            take = 1'b1;
          end
        end
        else if (MUX_MODE_I == `MUX_DIV3)
        begin
          next_buffer = {4'h0, 2'b00, seg7[17:16], seg7[15:12], 2'b00, seg7[9:8]};
          next_count = `STEP_SEG7_DIV3;
          take = 1'b1;
        end
        else if (MUX_MODE_I == `MUX_DIV4)
        begin
          next_buffer = {8'h00, seg7[7:4], 1'b0, seg7[2:0]};
          next_count = `STEP_SEG7_DIV4;
          take = 1'b1;
        end
      end
      else
      begin
        take = 1'b1;
        case (MUX_MODE_I)
          `MUX_STATIC:
          begin
            next_buffer = {3'h0, BYTE_I[3], 3'h0, BYTE_I[2], 3'h0, BYTE_I[1], 3'h0, BYTE_I[0]};
            next_count = `STEP_STATIC;
          end
          `MUX_DIV2:
          begin
            next_buffer = {2'h0, BYTE_I[7:6], 2'h0, BYTE_I[5:4],
                           2'h0, BYTE_I[3:2], 2'h0, BYTE_I[1:0]};
            next_count = `STEP_DIV2;
          end
          `MUX_DIV3:
          begin
            next_buffer = {4'h0, 2'b00, BYTE_I[7:6], 1'b0, BYTE_I[5:3], 1'b0, BYTE_I[2:0]};
            next_count = `STEP_DIV3;
          end
          default:
          begin
            next_buffer = {8'h00, BYTE_I};
            next_count = `STEP_DIV4;
          end
        endcase
      end
    end
  end

  // One word per cycle; pointer steps once per byte word written, not on nibble or bit commands
  always @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state <= ST_IDLE;
      buffer <= 16'h0000;
      count <= 3'h0;
      DATA_PTR_O <= `PTR_RESET;
      BUSY_O <= 1'b0;
      RD_DATA_O <= 4'h0;
      for (i = 0; i < `MEM_WORDS; i = i + 1)
        mem[i] <= 4'h0;
    end
    else
    begin
      RD_DATA_O <= mem[RD_ADDR_I];
      case (state)
        ST_IDLE:
        begin
          if (take)
          begin
            state <= ST_WRITE;
            buffer <= next_buffer;
            count <= next_count;
            BUSY_O <= 1'b1;
          end
          else if (PTR_CLEAR_I)
            DATA_PTR_O <= `PTR_RESET;
          else if (PTR_LOAD_I)
            DATA_PTR_O <= PTR_VALUE_I;
          else if (NIB_WRITE_I)
            mem[DATA_PTR_O] <= NIB_DATA_I;
          else if (BIT_WRITE_I)
            mem[DATA_PTR_O][BIT_SEL_I] <= BIT_VALUE_I;
        end
        ST_WRITE:
        begin
          mem[DATA_PTR_O] <= buffer[3:0];
          buffer <= {4'h0, buffer[15:4]};
          DATA_PTR_O <= DATA_PTR_O + 5'h01;
          count <= count - 3'h1;
          if (count == 3'h1)
          begin
            state <= ST_IDLE;
            BUSY_O <= 1'b0;
          end
        end
        default:
        begin
          state <= ST_IDLE;
          BUSY_O <= 1'b0;
        end
      endcase
    end
  end

endmodule

// file: lcd_sdw_sva.sv
// Checker on byte write timing and pointer steps
`timescale 1ns/1ps
module lcd_sdw_sva
(
  input wire       SYS_CLK_I,
  input wire       RST_N_I,
  input wire       BYTE_VALID_I,
  input wire [7:0] BYTE_I,
  input wire       CMD_SEL_I,
  input wire       DECODE_ON_I,
  input wire [1:0] MUX_MODE_I,
  input wire       PTR_CLEAR_I,
  input wire [4:0] DATA_PTR_O,
  input wire       BUSY_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire tk  = BYTE_VALID_I && !CMD_SEL_I && !BUSY_O;
  wire d4  = MUX_MODE_I == 2'h3;
  wire s7  = tk && DECODE_ON_I && !BYTE_I[7];
  wire s14 = tk && DECODE_ON_I && BYTE_I[7];
  raw_busy_a: assert property (tk && !DECODE_ON_I && d4 |=> BUSY_O [*2] ##1 !BUSY_O)
    else $error("raw write length");
  s7_busy_a: assert property (s7 && MUX_MODE_I == 2'h2 |=> BUSY_O [*3] ##1 !BUSY_O)
    else $error("decoded div3 length");
  s14_busy_a: assert property (s14 && d4 |=> BUSY_O [*4] ##1 !BUSY_O)
    else $error("wide decode length");
  s14_step_a: assert property (s14 && d4 |-> ##5 DATA_PTR_O - $past(DATA_PTR_O, 5) == 5'h04)
    else $error("wide decode step");
  s7_step_a: assert property (s7 && d4 |-> ##3 DATA_PTR_O - $past(DATA_PTR_O, 3) == 5'h02)
    else $error("narrow decode step");
  bad_mode_a: assert property ((s14 && !d4) || (s7 && !MUX_MODE_I[1]) |=> !BUSY_O)
    else $error("illegal decode taken");
  cmd_skip_a: assert property (BYTE_VALID_I && CMD_SEL_I && !BUSY_O |=> !BUSY_O)
    else $error("command byte written");
  clear_ptr_a: assert property (PTR_CLEAR_I && !BUSY_O && !BYTE_VALID_I |=> DATA_PTR_O == 5'h00)
    else $error("pointer not cleared");
  cover property (s14 && d4);
  cover property (s7 && d4);
  cover property (tk && !DECODE_ON_I);
  cover property (tk && !DECODE_ON_I && MUX_MODE_I == 2'h0);
endmodule

bind lcd_segment_decoder_writer lcd_sdw_sva chk
(
  .SYS_CLK_I   (SYS_CLK_I),
  .RST_N_I     (RST_N_I),
  .BYTE_VALID_I(BYTE_VALID_I),
  .BYTE_I      (BYTE_I),
  .CMD_SEL_I   (CMD_SEL_I),
  .DECODE_ON_I (DECODE_ON_I),
  .MUX_MODE_I  (MUX_MODE_I),
  .PTR_CLEAR_I (PTR_CLEAR_I),
  .DATA_PTR_O  (DATA_PTR_O),
  .BUSY_O      (BUSY_O)
);

// file: lcd_host.sv
// Host model that hands bytes to the writer
`timescale 1ns/1ps
module lcd_host
(
  input  wire       clk_i,
  output reg        valid_o = 1'b0,
  output reg  [7:0] byte_o = 8'h00,
  output reg        cmd_o = 1'b0
);
  // Lines scrambled after the strobe so stale data never matches
  task put(input [7:0] b, input c);
  begin
    @(negedge clk_i);
    valid_o = 1'b1;
    byte_o = b;
    cmd_o = c;
    @(negedge clk_i);
    valid_o = 1'b0;
    byte_o = ~b;
    cmd_o = ~c;
  end
  endtask
endmodule

// file: test_lcd_segment_decoder_writer.sv
// Self-checking bench for the segment decoder writer
`timescale 1ns/1ps
module test_lcd_segment_decoder_writer;
  reg        clk = 1'b0;
  reg        rst_n = 1'b0;
  reg        dec = 1'b0;
  reg  [1:0] mode = 2'h0;
  reg  [3:0] op = 4'h0;
  reg  [4:0] val = 5'h00;
  reg  [4:0] addr = 5'h00;
  wire       valid;
  wire [7:0] data;
  wire       cmd;
  wire [3:0] rd;
  wire [4:0] ptr;
  wire       busy;
  integer    mismatches = 0;
  integer    check_count = 0;
  always #2 clk = ~clk;
  lcd_host u_host (.clk_i(clk), .valid_o(valid), .byte_o(data), .cmd_o(cmd));
  lcd_segment_decoder_writer dut
  (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .BYTE_VALID_I(valid), .BYTE_I(data),
    .CMD_SEL_I(cmd), .DECODE_ON_I(dec), .MUX_MODE_I(mode), .PTR_CLEAR_I(op[3]),
    .PTR_LOAD_I(op[2]), .PTR_VALUE_I(val), .NIB_WRITE_I(op[1]), .NIB_DATA_I(val[3:0]),
    .BIT_WRITE_I(op[0]), .BIT_SEL_I(val[1:0]), .BIT_VALUE_I(val[4]),
    .RD_ADDR_I(addr), .RD_DATA_O(rd), .DATA_PTR_O(ptr), .BUSY_O(busy)
  );
  task stop_test;
  begin
    if (mismatches == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task fail(input [8*16-1:0] m);
  begin
    mismatches = mismatches + 1;
    $display("Error at %0t: %0s", $time, m);
  end
  endtask
  task pulse(input [3:0] o, input [4:0] v);
  begin
    @(negedge clk);
    op = o;
    val = v;
    @(negedge clk);
    op = 4'h0;
  end
  endtask
  // k is the number of words the byte must occupy; 0 when it is refused
  task go(input [7:0] b, input [1:0] m, input d, input [2:0] k);
    integer n;
  begin
    mode = m;
    dec = d;
    u_host.put(b, 1'b0);
    n = 0;
    while (busy !== 1'b0 && n < 20)
    begin
      @(negedge clk);
      n = n + 1;
    end
    check_count = check_count + 1;
    if (busy !== 1'b0)
    begin
      fail("busy timeout");
      stop_test;
    end
    else if (n != k)
      fail("busy length");
  end
  endtask
  task ck(input [4:0] a, input [3:0] e);
  begin
    addr = a;
    @(negedge clk);
    check_count = check_count + 1;
    if (rd !== e)
      fail("memory word");
  end
  endtask
  task cp(input [4:0] e);
  begin
    check_count = check_count + 1;
    if (ptr !== e)
      fail("pointer");
  end
  endtask
  task t_raw;
  begin
    pulse(4'h4, 5'h1f);
    go(8'ha5, 2'h3, 1'b0, 3'h2);
    ck(5'h1f, 4'h5);
    ck(5'h00, 4'ha);
    cp(5'h01);
    go(8'hff, 2'h2, 1'b0, 3'h3);
    ck(5'h03, 4'h3);
    cp(5'h04);
  end
  endtask
  task t_seg;
  begin
    pulse(4'h8, 5'h00);
    go(8'h72, 2'h2, 1'b1, 3'h3);
    ck(5'h00, 4'h1);
    ck(5'h01, 4'h7);
    ck(5'h02, 4'h2);
    go(8'h05, 2'h3, 1'b1, 3'h2);
    ck(5'h03, 4'h5);
    ck(5'h04, 4'hb);
    go(8'hc1, 2'h3, 1'b1, 3'h4);
    ck(5'h05, 4'h4);
    ck(5'h06, 4'h6);
    ck(5'h08, 4'h2);
    cp(5'h09);
  end
  endtask
  task t_skip;
  begin
    go(8'h81, 2'h2, 1'b1, 3'h0);
    cp(5'h09);
    ck(5'h0a, 4'h0);
    u_host.put(8'h33, 1'b1);
    cp(5'h09);
    pulse(4'h2, 5'h09);
    pulse(4'h1, 5'h12);
    ck(5'h09, 4'hd);
    cp(5'h09);
  end
  endtask
  task t_wide;
  begin
    pulse(4'h4, 5'h0c);
    go(8'h5a, 2'h0, 1'b0, 3'h4);
    ck(5'h0c, 4'h0);
    ck(5'h0d, 4'h1);
    ck(5'h0f, 4'h1);
    go(8'h9c, 2'h1, 1'b0, 3'h4);
    ck(5'h11, 4'h3);
    ck(5'h13, 4'h2);
    go(8'h05, 2'h1, 1'b1, 3'h0);
    go(8'h85, 2'h0, 1'b1, 3'h0);
    cp(5'h14);
  end
  endtask
  task t_reset;
  begin
    mode = 2'h3;
    dec = 1'b0;
    // Reset lands after the byte is taken, before its first word
    u_host.put(8'hee, 1'b0);
    rst_n = 1'b0;
    @(negedge clk);
    check_count = check_count + 1;
    if (busy !== 1'b0)
      fail("busy in reset");
    cp(5'h00);
    rst_n = 1'b1;
    ck(5'h09, 4'h0);
    ck(5'h14, 4'h0);
  end
  endtask
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    t_raw;
    t_seg;
    t_skip;
    t_wide;
    t_reset;
    stop_test;
  end
endmodule
